// ---- pushbutton_telegram_builder.sv ----
// Telegram framer of a self-powered pushbutton transmitter
// Behaviour
// R01 - Nonce: address, counter, three zero bytes
// R02 - Nonce address and counter LSB first
// R03 - 32-bit CCM tag over authenticated payload
// R04 - Key: factory default, alternate when selected
// R05 - Auth payload: 0C FF id counter state
// R06 - Tag appended after data payload
// R07 - Commissioning payload 30 bytes, length 1D
// R08 - Second commissioning byte is FF
// R09 - Maker id follows, software replaceable
// R10 - Counter from zero, +1 per data or commissioning telegram
// R11 - Factory key follows counter
// R12 - Source address ends commissioning payload
// R13 - Control bit selects mesh protocol mode
// R14 - Mesh: pending decommission request sent
// R15 - Mesh: commission on learn or request
// R16 - Learn held: only first-seen direction commissions
// R17 - Request gives one telegram, then clears
// R18 - Otherwise each actuation gives data
// R19 - Channel 11..26, default 11
// R20 - State bits: press, aux one, two
// R21 - Table entry FF suppresses data telegram
// R22 - Mesh data sent thrice, 2.5 ms apart
// R23 - Decommission wins, commission request kept
// R24 - Counter advanced before nonce built
`timescale 1ns/1ps
`default_nettype none
module pushbutton_telegram_builder #(
	parameter int unsigned GAP_CYCLES = telegram_pkg::GAP_CYCLES
) (
	// Clock and reset
	input  wire logic         i_mclk,
	input  wire logic         i_srst,
	// Wishbone slave
	input  wire logic         i_wb_cyc,
	input  wire logic         i_wb_stb,
	input  wire logic         i_wb_we,
	input  wire logic [7:0]   i_wb_adr,
	input  wire logic [31:0]  i_wb_dat,
	input  wire logic [3:0]   i_wb_sel,
	output logic      [31:0]  o_wb_dat,
	output logic              o_wb_ack,
	// Harvester and contact pins
	input  wire logic         i_actuate,
	input  wire logic         i_press_dir,
	input  wire logic         i_learn_button,
	input  wire logic         i_aux_contact_one,
	input  wire logic         i_aux_contact_two,
	// Device identity
	input  wire logic [127:0] i_factory_auth_key,
	input  wire logic [47:0]  i_source_address,
	// CCM engine
	output logic              o_ccm_start,
	output logic      [127:0] o_ccm_key,
	output logic      [103:0] o_ccm_nonce,
	output logic      [71:0]  o_ccm_auth_data,
	input  wire logic         i_ccm_done,
	input  wire logic [31:0]  i_ccm_tag,
	// Radio byte stream
	output logic              o_tx_valid,
	output logic      [7:0]   o_tx_data,
	output logic              o_tx_last,
	input  wire logic         i_tx_ready,
	output logic      [1:0]   o_tx_kind,
	output logic      [4:0]   o_tx_channel,
	output logic              o_tx_mesh,
	output logic              o_busy
);
	typedef enum logic [1:0] {ST_IDLE, ST_SIGN, ST_SEND, ST_GAP} state_t;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	state_t        state;
	logic [4:0]    ctrl;
	logic [4:0]    channel;
	logic [15:0]   maker_id;
	logic [31:0]   seq_count;
	logic [63:0]   enc_table;
	logic [31:0]   alt_key [4];
	logic [239:0]  frame;
	logic [4:0]    frame_len;
	logic [4:0]    byte_idx;
	logic [1:0]    sends_left;
	logic [1:0]    kind;
	logic [16:0]   gap_cnt;
	logic [7:0]    lfsr;
	logic          learn_lock;
	logic          lock_dir;
	logic [4:0]    sync1;
	logic [4:0]    sync2;
	logic          act_prev;
	logic          act_evt;
	logic          wb_req;
	logic          wb_wr;
	logic [127:0]  alt_flat;
	logic          start_decomm;
	logic          start_comm;
	logic          start_data;
	logic          skip_data;
	logic [7:0]    state_byte;
	logic [2:0]    enc_idx;
	logic [7:0]    enc_entry;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge i_mclk) begin
		sync1 <= {i_actuate, i_press_dir, i_learn_button, i_aux_contact_one,
			i_aux_contact_two};
		sync2 <= sync1;
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			act_prev <= 1'b0;
		end else begin
			act_prev <= sync2[4];
		end
	end
	assign act_evt = sync2[4] & ~act_prev;

	////////////////////////////////////////////////////////////////
	// Wishbone slave
	assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	assign wb_wr  = wb_req & i_wb_we;

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= wb_req;
			if (wb_req && !i_wb_we) begin
				unique case (i_wb_adr)
					telegram_pkg::ADR_CTRL:    o_wb_dat <= {27'h0, ctrl};
					telegram_pkg::ADR_CHANNEL: o_wb_dat <= {27'h0, channel};
					telegram_pkg::ADR_MAKER:   o_wb_dat <= {16'h0, maker_id};
					telegram_pkg::ADR_SEQ:     o_wb_dat <= seq_count;
					telegram_pkg::ADR_STATUS:  o_wb_dat <= {26'h0, lock_dir, learn_lock,
						kind, o_busy, o_tx_valid};
					telegram_pkg::ADR_ENC_LO:  o_wb_dat <= enc_table[31:0];
					telegram_pkg::ADR_ENC_HI:  o_wb_dat <= enc_table[63:32];
					default: begin
						if (i_wb_adr[7:4] == 4'h2 && i_wb_adr[1:0] == 2'h0) begin
							o_wb_dat <= alt_key[i_wb_adr[3:2]];
						end else begin
							o_wb_dat <= 32'h0000_0000;
						end
					end
				endcase
			end
		end
	end

	// Control; a hardware clear loses to a software write in the same cycle
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			ctrl <= 5'h00;
		end else if (wb_wr && i_wb_adr == telegram_pkg::ADR_CTRL && i_wb_sel[0]) begin
			ctrl <= i_wb_dat[4:0]; // [R13]
		end else begin
			if (start_comm && !sync2[2]) begin
				ctrl[telegram_pkg::CTRL_COMM] <= 1'b0; // [R17]
			end
			if (start_decomm) begin
				ctrl[telegram_pkg::CTRL_DECOMM] <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			channel <= telegram_pkg::CHAN_MIN; // [R19]
		end else if (wb_wr && i_wb_adr == telegram_pkg::ADR_CHANNEL && i_wb_sel[0]
			&& i_wb_dat[7:0] >= {3'h0, telegram_pkg::CHAN_MIN}
			&& i_wb_dat[7:0] <= {3'h0, telegram_pkg::CHAN_MAX}) begin
			channel <= i_wb_dat[4:0]; // [R19]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			maker_id <= telegram_pkg::MAKER_RESET;
		end else if (wb_wr && i_wb_adr == telegram_pkg::ADR_MAKER) begin
			maker_id <= 16'(merge({16'h0, maker_id}, i_wb_dat, i_wb_sel)); // [R09]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			enc_table <= telegram_pkg::ENC_RESET;
		end else if (wb_wr && i_wb_adr == telegram_pkg::ADR_ENC_LO) begin
			enc_table[31:0] <= merge(enc_table[31:0], i_wb_dat, i_wb_sel);
		end else if (wb_wr && i_wb_adr == telegram_pkg::ADR_ENC_HI) begin
			enc_table[63:32] <= merge(enc_table[63:32], i_wb_dat, i_wb_sel);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			for (int k = 0; k < 4; k++) begin
				alt_key[k] <= 32'h0000_0000;
			end
		end else if (wb_wr && i_wb_adr[7:4] == 4'h2 && i_wb_adr[1:0] == 2'h0) begin
			alt_key[i_wb_adr[3:2]] <= merge(alt_key[i_wb_adr[3:2]], i_wb_dat, i_wb_sel);
		end
	end
	assign alt_flat = {alt_key[3], alt_key[2], alt_key[1], alt_key[0]};

	////////////////////////////////////////////////////////////////
	// Telegram decision
	assign state_byte = {5'h00, sync2[0], sync2[1], sync2[3]}; // [R20]
	assign enc_idx    = {sync2[0], sync2[1], ~sync2[3]};
	assign enc_entry  = enc_table[{enc_idx, 3'b000} +: 8];

	always_comb begin
		start_decomm = 1'b0;
		start_comm   = 1'b0;
		start_data   = 1'b0;
		skip_data    = 1'b0;
		if (act_evt && state == ST_IDLE) begin
			if (ctrl[telegram_pkg::CTRL_MESH] && ctrl[telegram_pkg::CTRL_DECOMM]) begin
				start_decomm = 1'b1; // [R14] [R23]
			end else if (sync2[2]) begin
				start_comm = !learn_lock || lock_dir == sync2[3]; // [R15] [R16]
			end else if (ctrl[telegram_pkg::CTRL_COMM]) begin
				start_comm = 1'b1; // [R15] [R17]
			end else if (ctrl[telegram_pkg::CTRL_ENC_EN]
				&& enc_entry == telegram_pkg::ENC_SKIP) begin
				skip_data = 1'b1; // [R21]
			end else begin
				start_data = 1'b1; // [R18]
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			learn_lock <= 1'b0;
			lock_dir   <= 1'b0;
		end else if (!sync2[2]) begin
			learn_lock <= 1'b0;
		end else if (start_comm && !learn_lock) begin
			learn_lock <= 1'b1; // [R16]
			lock_dir   <= sync2[3];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			seq_count <= telegram_pkg::SEQ_RESET; // [R10]
		end else if (start_data || start_comm) begin
			seq_count <= seq_count + 32'h0000_0001; // [R10] [R24]
		end
	end

	////////////////////////////////////////////////////////////////
	// Framer
	wire [31:0] seq_new = seq_count + 32'h0000_0001;

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state       <= ST_IDLE;
			frame       <= '0;
			frame_len   <= 5'h00;
			byte_idx    <= 5'h00;
			sends_left  <= 2'h0;
			kind        <= telegram_pkg::KIND_DATA;
			gap_cnt     <= 17'h00000;
			o_ccm_start <= 1'b0;
		end else begin
			o_ccm_start <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					byte_idx <= 5'h00;
					if (start_data) begin
						frame      <= '0;
						frame[71:0] <= {(ctrl[telegram_pkg::CTRL_ENC_EN] ? enc_entry
							: state_byte), seq_new, maker_id,
							telegram_pkg::TYPE_BYTE, telegram_pkg::DATA_LEN_BYTE}; // [R05]
						frame_len  <= telegram_pkg::DATA_BYTES;
						kind       <= telegram_pkg::KIND_DATA;
						sends_left <= ctrl[telegram_pkg::CTRL_MESH] ?
							telegram_pkg::DATA_SENDS : 2'd1; // [R22]
						o_ccm_start <= 1'b1; // [R03]
						state      <= ST_SIGN;
					end else if (start_comm) begin
						frame <= {i_source_address, i_factory_auth_key, seq_new, maker_id,
							telegram_pkg::TYPE_BYTE, telegram_pkg::COMM_LEN_BYTE}; // [R07] [R08] [R11] [R12]
						frame_len  <= telegram_pkg::COMM_BYTES;
						kind       <= telegram_pkg::KIND_COMM;
						sends_left <= ctrl[telegram_pkg::CTRL_MESH] ?
							telegram_pkg::COMM_SENDS : 2'd1;
						state      <= ST_SEND;
					end else if (start_decomm) begin
						frame      <= {232'h0, telegram_pkg::DECOMM_BYTE};
						frame_len  <= telegram_pkg::DECOMM_BYTES;
						kind       <= telegram_pkg::KIND_DECOMM;
						sends_left <= 2'd1;
						state      <= ST_SEND;
					end
				end
				ST_SIGN: begin
					if (i_ccm_done) begin
						frame[8*telegram_pkg::TAG_POS +: 32] <= i_ccm_tag; // [R06]
						state <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (i_tx_ready) begin
						if (byte_idx == frame_len - 5'd1) begin
							byte_idx   <= 5'h00;
							sends_left <= sends_left - 2'd1;
							gap_cnt    <= 17'(GAP_CYCLES) + {7'h0, lfsr, 2'b00}; // [R22]
							state      <= (sends_left == 2'd1) ? ST_IDLE : ST_GAP;
						end else begin
							byte_idx <= byte_idx + 5'd1;
						end
					end
				end
				ST_GAP: begin
					gap_cnt <= gap_cnt - 17'd1;
					if (gap_cnt <= 17'd1) begin
						state <= ST_SEND;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			lfsr <= 8'h01;
		end else begin
			lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		end
	end

	assign o_ccm_key = ctrl[telegram_pkg::CTRL_KEYSEL] ? alt_flat
		: i_factory_auth_key; // [R04]
	assign o_ccm_nonce = {24'h000000, frame[63:32], i_source_address}; // [R01] [R02]
	assign o_ccm_auth_data = frame[71:0]; // [R05]
	assign o_tx_valid   = (state == ST_SEND);
	assign o_tx_data    = frame[{byte_idx, 3'b000} +: 8];
	assign o_tx_last    = o_tx_valid && byte_idx == frame_len - 5'd1;
	assign o_tx_kind    = kind;
	assign o_tx_channel = channel;
	assign o_tx_mesh    = ctrl[telegram_pkg::CTRL_MESH];
	assign o_busy       = (state != ST_IDLE);

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);

	sequence s_comm_start;
		state == ST_SEND && kind == telegram_pkg::KIND_COMM && byte_idx == 5'd0;
	endsequence
	sequence s_last_taken;
		o_tx_last && i_tx_ready;
	endsequence

	property p_nonce;
		o_ccm_start |-> o_ccm_nonce[103:80] == 24'h0 && o_ccm_nonce[79:48] == seq_count
			&& o_ccm_nonce[47:0] == i_source_address;
	endproperty
	a_nonce: assert property (p_nonce) else $error("nonce layout wrong"); // [R01]
	property p_key;
		o_ccm_start |-> o_ccm_key == (ctrl[1] ? alt_flat : i_factory_auth_key);
	endproperty
	a_key: assert property (p_key) else $error("signing key wrong"); // [R04]
	property p_auth;
		o_ccm_start |-> o_ccm_auth_data[15:0] == 16'hff0c
			&& o_ccm_auth_data[31:16] == maker_id;
	endproperty
	a_auth: assert property (p_auth) else $error("auth payload wrong"); // [R05]
	property p_tag;
		state == ST_SIGN && i_ccm_done |=> frame[103:72] == $past(i_ccm_tag);
	endproperty
	a_tag: assert property (p_tag) else $error("tag not appended"); // [R06]
	property p_comm_len;
		s_comm_start |-> o_tx_data == 8'h1d && frame_len == 5'd30;
	endproperty
	a_comm_len: assert property (p_comm_len) else $error("bad commissioning header"); // [R07]
	property p_seq;
		start_data || start_comm |=> seq_count == $past(seq_count) + 32'h1;
	endproperty
	a_seq: assert property (p_seq) else $error("counter not advanced"); // [R10]
	property p_chan;
		o_tx_channel >= 5'd11 && o_tx_channel <= 5'd26;
	endproperty
	a_chan: assert property (p_chan) else $error("channel out of range"); // [R19]
	property p_repeat;
		s_last_taken ##0 (sends_left > 2'd1) |=> state == ST_GAP [*2];
	endproperty
	a_repeat: assert property (p_repeat) else $error("no gap between repeats"); // [R22]
	property p_keep_comm;
		start_decomm && ctrl[3] |=> ctrl[3];
	endproperty
	a_keep_comm: assert property (p_keep_comm) else $error("commission request lost"); // [R23]
	property p_skip;
		skip_data |=> !o_busy && $stable(seq_count);
	endproperty
	a_skip: assert property (p_skip) else $error("suppressed event sent"); // [R21]
endmodule : pushbutton_telegram_builder
`default_nettype wire

// ---- telegram_pkg.sv ----
// Shared constants of the pushbutton telegram builder
package telegram_pkg;
	// Register byte addresses
	localparam logic [7:0] ADR_CTRL     = 8'h00;
	localparam logic [7:0] ADR_CHANNEL  = 8'h04;
	localparam logic [7:0] ADR_MAKER    = 8'h08;
	localparam logic [7:0] ADR_SEQ      = 8'h0c;
	localparam logic [7:0] ADR_STATUS   = 8'h10;
	localparam logic [7:0] ADR_ENC_LO   = 8'h14;
	localparam logic [7:0] ADR_ENC_HI   = 8'h18;
	localparam logic [7:0] ADR_ALT_KEY0 = 8'h20;
	// Control field positions
	localparam int CTRL_MESH   = 0;
	localparam int CTRL_KEYSEL = 1;
	localparam int CTRL_ENC_EN = 2;
	localparam int CTRL_COMM   = 3;
	localparam int CTRL_DECOMM = 4;
	// Reset values; maker id value is arbitrary
	localparam logic [4:0]  CHAN_MIN     = 5'h0b;
	localparam logic [4:0]  CHAN_MAX     = 5'h1a;
	localparam logic [15:0] MAKER_RESET  = 16'h5a5a;
	localparam logic [31:0] SEQ_RESET    = 32'h0000_0000;
	localparam logic [63:0] ENC_RESET    = 64'h0607_0405_0203_0001;
	// Payload bytes
	localparam logic [7:0]  DATA_LEN_BYTE = 8'h0c;
	localparam logic [7:0]  COMM_LEN_BYTE = 8'h1d;
	localparam logic [7:0]  TYPE_BYTE     = 8'hff;
	localparam logic [7:0]  ENC_SKIP      = 8'hff;
	localparam logic [7:0]  DECOMM_BYTE   = 8'he1;
	localparam logic [4:0]  DATA_BYTES    = 5'd13;
	localparam logic [4:0]  COMM_BYTES    = 5'd30;
	localparam logic [4:0]  DECOMM_BYTES  = 5'd1;
	localparam int          TAG_POS       = 9;
	// Repeats per telegram kind in mesh mode
	localparam logic [1:0]  DATA_SENDS    = 2'd3;
	localparam logic [1:0]  COMM_SENDS    = 2'd2;
	// Telegram kinds
	localparam logic [1:0]  KIND_DATA     = 2'd0;
	localparam logic [1:0]  KIND_COMM     = 2'd1;
	localparam logic [1:0]  KIND_DECOMM   = 2'd2;
	// Timing
	localparam int          CLK_PERIOD_NS = 40;
	localparam int          REPEAT_GAP_NS = 2500000;
	localparam int          GAP_CYCLES    = REPEAT_GAP_NS / CLK_PERIOD_NS;
	localparam int          JITTER_SHIFT  = 2;
endpackage : telegram_pkg

// ---- radio_receiver_model.sv ----
// Radio sink and signing engine stand-in on the far side of the builder
`timescale 1ns/1ps
`default_nettype none
module radio_receiver_model #(
	parameter logic [31:0] TAG = 32'hc3b2_a190
) (
	// Clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_srst,
	// Stall select
	input  wire logic        i_slow,
	// Signing engine side
	input  wire logic        i_ccm_start,
	output logic             o_ccm_done,
	output logic      [31:0] o_ccm_tag,
	// Byte stream side
	input  wire logic        i_tx_valid,
	input  wire logic [7:0]  i_tx_data,
	output logic             o_tx_ready
);
	logic [7:0] rx_q[$];
	logic [2:0] sign_cnt;
	logic       toggle;
	// Tag is garbage outside the done cycle
	assign o_ccm_tag  = o_ccm_done ? TAG : ~TAG;
	assign o_tx_ready = !i_slow || toggle;
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			sign_cnt   <= 3'h0;
			o_ccm_done <= 1'b0;
			toggle     <= 1'b0;
		end else begin
			toggle     <= !toggle;
			o_ccm_done <= (sign_cnt == 3'h1);
			if (i_ccm_start)
				sign_cnt <= 3'h4;
			else if (sign_cnt != 3'h0)
				sign_cnt <= sign_cnt - 3'h1;
		end
	end
	always @(posedge i_mclk) begin
		if (!i_srst && i_tx_valid && o_tx_ready)
			rx_q.push_back(i_tx_data);
	end
endmodule : radio_receiver_model
`default_nettype wire

// ---- pushbutton_telegram_builder_tb.sv ----
// Self-checking bench of the pushbutton telegram builder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module pushbutton_telegram_builder_tb;
	localparam logic [127:0] FKEY = 128'h0f0e0d0c_0b0a0908_07060504_03020100;
	localparam logic [127:0] AKEY = 128'hf0e1d2c3_b4a59687_78695a4b_3c2d1e0f;
	localparam logic [47:0]  SADR = 48'h6655_4433_2211;
	localparam logic [31:0]  TAG  = 32'hc3b2_a190;
	localparam logic [15:0]  MK   = telegram_pkg::MAKER_RESET;
	logic         i_mclk, i_srst, cyc, stb, we, ack, actv, dir, learn_button, aux1, aux2, slow;
	logic         ccm_start, done, txv, txl, rdy, mesh, busy;
	logic [7:0]   adr, txd;
	logic [31:0]  wdat, rdat, tag;
	logic [127:0] key, k_cap;
	logic [103:0] nonce, n_cap;
	logic [71:0]  auth, a_cap;
	logic [1:0]   kind, kind_cap;
	logic [4:0]   chan;
	logic [7:0]   ex[$];
	int           miscompares, cmp_count, lasts, cycles;

	pushbutton_telegram_builder #(.GAP_CYCLES(8)) dut (
		.i_mclk(i_mclk), .i_srst(i_srst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_actuate(actv), .i_press_dir(dir), .i_learn_button(learn_button),
		.i_aux_contact_one(aux1), .i_aux_contact_two(aux2),
		.i_factory_auth_key(FKEY), .i_source_address(SADR),
		.o_ccm_start(ccm_start), .o_ccm_key(key), .o_ccm_nonce(nonce), .o_ccm_auth_data(auth),
		.i_ccm_done(done), .i_ccm_tag(tag), .o_tx_valid(txv), .o_tx_data(txd),
		.o_tx_last(txl), .i_tx_ready(rdy), .o_tx_kind(kind), .o_tx_channel(chan),
		.o_tx_mesh(mesh), .o_busy(busy));
	radio_receiver_model #(.TAG(TAG)) radio (
		.i_mclk(i_mclk), .i_srst(i_srst), .i_slow(slow), .i_ccm_start(ccm_start),
		.o_ccm_done(done), .o_ccm_tag(tag), .i_tx_valid(txv), .i_tx_data(txd),
		.o_tx_ready(rdy));

	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cycles++;
		if (ccm_start === 1'b1) begin
			k_cap <= key;
			n_cap <= nonce;
			a_cap <= auth;
		end
		if (txv && rdy)
			kind_cap <= kind;
		if (txv && rdy && txl)
			lasts++;
		if (cycles == 40000) begin
			miscompares++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge i_mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge i_mclk);
		end while (ack !== 1'b1);
		q = rdat;
		`CHK("ack", 1'b1, ack)
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		`CHK(nm, e, q)
	endtask : rchk
	task automatic push(input logic [127:0] v, input int nb);
		for (int i = 0; i < nb; i++)
			ex.push_back(v[8 * i +: 8]);
	endtask : push
	task automatic comm_ex(input logic [31:0] cnt);
		ex = {};
		push({cnt, MK, 8'hff, 8'h1d}, 8);
		push(FKEY, 16);
		push({80'h0, SADR}, 6);
	endtask : comm_ex
	task automatic act(input logic d, input logic a1, input logic a2);
		radio.rx_q.delete();
		lasts = 0;
		@(posedge i_mclk);
		dir <= d;
		aux1 <= a1;
		aux2 <= a2;
		@(posedge i_mclk);
		actv <= 1'b1;
		repeat (8) @(posedge i_mclk);
		actv <= 1'b0;
		while (busy !== 1'b0) begin
			@(posedge i_mclk);
		end
	endtask : act
	task automatic chk_rx(input string nm, input int reps);
		`CHK({nm, " size"}, ex.size() * reps, radio.rx_q.size())
		`CHK({nm, " ends"}, reps, lasts)
		foreach (radio.rx_q[i])
			`CHK(nm, ex[i % ex.size()], radio.rx_q[i])
	endtask : chk_rx
	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		`CHK("chan rst", 5'h0b, chan)
		`CHK("mesh rst", 1'b0, mesh)
		rchk("ctrl", telegram_pkg::ADR_CTRL, 32'h0);
		rchk("maker", telegram_pkg::ADR_MAKER, {16'h0, MK});
		wr(telegram_pkg::ADR_SEQ, 32'h1234);
		rchk("seq", telegram_pkg::ADR_SEQ, 32'h0);
		rchk("unmapped", 8'h40, 32'h0);
		wr(telegram_pkg::ADR_CHANNEL, 32'h1a);
		wr(telegram_pkg::ADR_CHANNEL, 32'h1b);
		wr(telegram_pkg::ADR_CHANNEL, 32'h0a);
		rchk("chan", telegram_pkg::ADR_CHANNEL, 32'h1a);
		`CHK("chan pin", 5'h1a, chan)
		wr(telegram_pkg::ADR_CHANNEL, 32'h0b);
		$display("test regs done");
	endtask : t_regs
	task automatic t_data();
		ex = {};
		push({8'h03, 32'h1, MK, 8'hff, 8'h0c}, 9);
		push({96'h0, TAG}, 4);
		act(1'b1, 1'b1, 1'b0);
		`CHK("key", FKEY, k_cap)
		`CHK("nonce", {24'h0, 32'h1, SADR}, n_cap)
		`CHK("auth", {8'h03, 32'h1, MK, 8'hff, 8'h0c}, a_cap)
		chk_rx("data", 1);
		`CHK("kind", 2'd0, kind_cap)
		rchk("seq", telegram_pkg::ADR_SEQ, 32'h1);
		$display("test data done");
	endtask : t_data
	task automatic t_mesh();
		for (int i = 0; i < 4; i++)
			wr(telegram_pkg::ADR_ALT_KEY0 + 8'(4 * i), AKEY[32 * i +: 32]);
		wr(telegram_pkg::ADR_CTRL, 32'h3);
		`CHK("mesh", 1'b1, mesh)
		ex = {};
		push({8'h04, 32'h2, MK, 8'hff, 8'h0c}, 9);
		push({96'h0, TAG}, 4);
		slow <= 1'b1;
		act(1'b0, 1'b0, 1'b1);
		slow <= 1'b0;
		`CHK("alt key", AKEY, k_cap)
		chk_rx("mesh data", 3);
		$display("test mesh done");
	endtask : t_mesh
	task automatic t_comm();
		wr(telegram_pkg::ADR_CTRL, 32'h9);
		comm_ex(32'h3);
		act(1'b0, 1'b0, 1'b0);
		chk_rx("comm", 2);
		`CHK("comm kind", 2'd1, kind_cap)
		rchk("req clr", telegram_pkg::ADR_CTRL, 32'h1);
		wr(telegram_pkg::ADR_CTRL, 32'h19);
		ex = {8'he1};
		act(1'b1, 1'b0, 1'b0);
		chk_rx("decomm", 1);
		`CHK("decomm kind", 2'd2, kind_cap)
		rchk("req kept", telegram_pkg::ADR_CTRL, 32'h9);
		rchk("seq", telegram_pkg::ADR_SEQ, 32'h3);
		$display("test comm done");
	endtask : t_comm
	task automatic t_learn();
		wr(telegram_pkg::ADR_CTRL, 32'h1);
		learn_button <= 1'b1;
		repeat (4) @(posedge i_mclk);
		comm_ex(32'h4);
		act(1'b1, 1'b0, 1'b0);
		chk_rx("learn", 2);
		act(1'b0, 1'b0, 1'b0);
		chk_rx("learn other", 0);
		comm_ex(32'h5);
		act(1'b1, 1'b0, 1'b0);
		chk_rx("learn again", 2);
		learn_button <= 1'b0;
		$display("test learn done");
	endtask : t_learn
	task automatic t_skip();
		wr(telegram_pkg::ADR_CTRL, 32'h4);
		wr(telegram_pkg::ADR_ENC_LO, 32'h0203_ff5c);
		act(1'b0, 1'b0, 1'b0);
		chk_rx("skip", 0);
		rchk("seq", telegram_pkg::ADR_SEQ, 32'h5);
		ex = {};
		push({8'h5c, 32'h6, MK, 8'hff, 8'h0c}, 9);
		push({96'h0, TAG}, 4);
		act(1'b1, 1'b0, 1'b0);
		chk_rx("custom", 1);
		$display("test skip done");
	endtask : t_skip
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{cyc, stb, we, actv, dir, learn_button, aux1, aux2, slow} = 9'h0;
		adr = 8'h0;
		wdat = 32'h0;
		i_srst = 1'b1;
		repeat (12) @(posedge i_mclk);
		i_srst <= 1'b0;
		t_regs();
		t_data();
		t_mesh();
		t_comm();
		t_learn();
		t_skip();
		end_of_test();
	end
endmodule : pushbutton_telegram_builder_tb
`default_nettype wire
